// *** verif/ahb_arb_monitor_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module ahb_arb_monitor_test;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic ce = 1'b1;
    logic hsel_main = 1'b0;
    logic hsel_video = 1'b0;
    logic reg_act = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [7:0] start = 8'h00;
    logic [2:0] burst = 3'h0;
    logic [7:0] busreq;
    logic [1:0] mdl_trans;
    logic [2:0] mdl_burst;
    logic mdl_idle;
    logic [7:0] grant_m;
    logic [7:0] grant_v;
    logic [3:0] owner_m;
    logic [3:0] owner_v;
    logic [31:0] rdata_m;
    logic [31:0] rdata_v;
    logic [31:0] got;
    int err_count = 0;
    int tests_run = 0;
    // Register accesses take the bus only while the masters are quiet
    wire logic [1:0] htrans = reg_act ? 2'h2 : mdl_trans;
    wire logic [2:0] hburst = reg_act ? 3'h0 : mdl_burst;

    always #10 i_clk_sys = ~i_clk_sys;

    ahb_master_model i_ahb_master_model (.i_clk_sys(i_clk_sys),
        .i_rst(i_rst), .i_start(start), .i_burst(burst), .i_hgrant(grant_m),
        .i_hready(1'b1), .o_hbusreq(busreq), .o_htrans(mdl_trans),
        .o_hburst(mdl_burst), .o_idle(mdl_idle));
    ahb_arb_monitor #(.VIDEO_BUS(1'b0)) i_ahb_arb_monitor (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce),
        .i_hbusreq(busreq), .o_hgrant(grant_m), .o_hmaster(owner_m),
        .i_hsel(hsel_main), .i_haddr(haddr), .i_htrans(htrans),
        .i_hburst(hburst), .i_hwrite(hwrite), .i_hready(1'b1),
        .i_hwdata(hwdata), .o_hrdata(rdata_m), .o_hreadyout(), .o_hresp());
    ahb_arb_monitor #(.VIDEO_BUS(1'b1)) i_ahb_arb_monitor_video (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce),
        .i_hbusreq(busreq), .o_hgrant(grant_v), .o_hmaster(owner_v),
        .i_hsel(hsel_video), .i_haddr(haddr), .i_htrans(htrans),
        .i_hburst(hburst), .i_hwrite(hwrite), .i_hready(1'b1),
        .i_hwdata(hwdata), .o_hrdata(rdata_v), .o_hreadyout(), .o_hresp());

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic acc(input logic vid, input logic wr_n, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk_sys);
        hsel_main <= !vid;
        hsel_video <= vid;
        reg_act <= 1'b1;
        haddr <= a;
        hwrite <= wr_n;
        @(posedge i_clk_sys);
        hsel_main <= 1'b0;
        hsel_video <= 1'b0;
        reg_act <= 1'b0;
        hwdata <= d;
        @(negedge i_clk_sys);
        got = vid ? rdata_v : rdata_m;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask

    task automatic rdc(input logic v, input logic [7:0] a, input logic [31:0] e);
        acc(v, 1'b0, a, 32'h0000_0000);
        chk(got, e);
    endtask

    task automatic run_m(input logic [7:0] m, input logic [2:0] b);
        int n;
        @(posedge i_clk_sys);
        start <= m;
        burst <= b;
        @(posedge i_clk_sys);
        start <= 8'h00;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (mdl_idle !== 1'b1 && n < 200);
        chk({31'h0, mdl_idle}, 32'h0000_0001);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] pat [4] = '{32'hA5A5_A5A5, 32'h5A5A_5A5A,
                                 32'h0F1E_2D3C, 32'hC3D2_E1F0};
        chk({24'h0, grant_m}, 32'h0000_0001);
        for (int a = 0; a <= 24; a += 4) rdc(1'b0, 8'(a), 32'h0);
        wr(8'h00, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h00, 32'h0000_0003);
        wr(8'h04, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h04, 32'h00FF_7707);
        wr(8'h04, 32'h0000_0000);
        wr(8'h18, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h18, 32'h0000_0000);
        for (int i = 0; i < 4; i++) wr(8'(8 + 4 * i), pat[i]);
        for (int i = 0; i < 4; i++) rdc(1'b0, 8'(8 + 4 * i), pat[i]);
        $display("test regs done");
    endtask

    task automatic t_video();
        acc(1'b1, 1'b1, 8'h00, 32'h0000_0002);
        rdc(1'b1, 8'h00, 32'h0000_0002);
        acc(1'b1, 1'b1, 8'h08, 32'hFFFF_FFFF);
        rdc(1'b1, 8'h08, 32'h0000_0000);
        acc(1'b1, 1'b1, 8'h14, 32'hFFFF_FFFF);
        rdc(1'b1, 8'h14, 32'h0000_0000);
        run_m(8'h20, 3'h0);
        acc(1'b1, 1'b1, 8'h00, 32'h0000_0001);
        run_m(8'h01, 3'h0);
        chk({28'h0, owner_v}, 32'h0000_0000);
        rdc(1'b1, 8'h00, 32'h0000_0002);
        $display("test video done");
    endtask

    task automatic t_clock();
        wr(8'h08, 32'hFFFF_FFFE);
        wr(8'h14, 32'h0000_0000);
        wr(8'h04, 32'h0000_0001);
        @(posedge i_clk_sys) ce <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        ce <= 1'b1;
        wr(8'h04, 32'h0000_0000);
        rdc(1'b0, 8'h08, 32'h0000_0001);
        rdc(1'b0, 8'h14, 32'h0001_0000);
        $display("test clock done");
    endtask

    // Both channels watch master 2; master 5 parks the bus afterwards
    task automatic ev_run(input logic [2:0] ev0, input logic [2:0] ev1,
                          input logic [2:0] b1, input logic [2:0] b2,
                          input logic [31:0] e0, input logic [31:0] e1);
        wr(8'h14, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h10, 32'h0);
        wr(8'h04, {8'h00, 8'h22, 1'b0, ev1, 1'b0, ev0, 8'h06});
        run_m(8'h04, b1);
        run_m(8'h04, b2);
        run_m(8'h20, 3'h0);
        wr(8'h04, 32'h0);
        rdc(1'b0, 8'h0C, e0);
        rdc(1'b0, 8'h10, e1);
        rdc(1'b0, 8'h14, 32'h0);
        $display("test events done");
    endtask

    task automatic t_sat();
        wr(8'h14, 32'h0000_FEFF);
        wr(8'h0C, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0000_0000);
        wr(8'h04, 32'h003F_3006);
        run_m(8'h08, 3'h0);
        run_m(8'h20, 3'h0);
        run_m(8'h08, 3'h0);
        run_m(8'h20, 3'h0);
        wr(8'h04, 32'h0);
        rdc(1'b0, 8'h0C, 32'hFFFF_FFFF);
        rdc(1'b0, 8'h10, 32'h0000_0000);
        rdc(1'b0, 8'h14, 32'h0000_FFFF);
        $display("test saturate done");
    endtask

    task automatic t_groups();
        logic [7:0] hi [4] = '{8'h16, 8'h15, 8'h13, 8'h1A};
        logic [7:0] seen;
        int n;
        for (int s = 0; s < 4; s++) begin
            wr(8'h00, 32'(s));
            @(posedge i_clk_sys);
            start <= 8'hFF;
            burst <= 3'h0;
            @(posedge i_clk_sys);
            start <= 8'h00;
            seen = 8'h00;
            n = 0;
            for (int k = 0; k < 300 && n < 8; k++) begin
                @(negedge i_clk_sys);
                if (mdl_trans === 2'h2) begin
                    seen[owner_m[2:0]] = 1'b1;
                    n++;
                    if (n == 3) chk({24'h0, seen}, {24'h0, hi[s]});
                end
            end
            chk({24'h0, seen}, 32'h0000_00FF);
        end
        $display("test groups done");
    endtask

    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_regs();
        t_video();
        t_clock();
        ev_run(3'h1, 3'h5, 3'h3, 3'h4, 32'h2, 32'h2);
        ev_run(3'h0, 3'h6, 3'h1, 3'h0, 32'h5, 32'h1);
        ev_run(3'h5, 3'h6, 3'h1, 3'h2, 32'h1, 32'h1);
        ev_run(3'h4, 3'h1, 3'h0, 3'h7, 32'h1, 32'h2);
        ev_run(3'h2, 3'h0, 3'h0, 3'h0, 32'h1, 32'h2);
        t_sat();
        t_groups();
        test_done();
    end

    // Whole run needs under a thousand cycles; this is a generous ceiling
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire

// *** verif/ahb_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ahb_master_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Commands from the bench
    input wire logic [7:0] i_start,
    input wire logic [2:0] i_burst,
    // Arbiter and shared bus
    input wire logic [7:0] i_hgrant,
    input wire logic i_hready,
    output logic [7:0] o_hbusreq,
    output logic [1:0] o_htrans,
    output logic [2:0] o_hburst,
    output logic o_idle
);
    // ----------------------------------------
    // Request and beat tracking
    // ----------------------------------------
    logic [7:0] pending;
    logic [7:0] armed;
    logic [3:0] beats_left;
    logic issue;
    logic [7:0] next_pending;

    // Undefined length INCR runs four beats here
    function automatic logic [3:0] burst_len(input logic [2:0] code);
        case (code)
            3'h0: burst_len = 4'h0;
            3'h1, 3'h2, 3'h3: burst_len = 4'h3;
            3'h4, 3'h5: burst_len = 4'h7;
            default: burst_len = 4'hF;
        endcase
    endfunction

    // Armed delays a fresh request past one arbitration edge
    assign issue = (beats_left == 4'h0) && |(pending & armed & i_hgrant);
    assign o_htrans = (beats_left != 4'h0) ? 2'h3 : (issue ? 2'h2 : 2'h0);
    assign o_hburst = i_burst;
    assign o_hbusreq = pending;
    assign o_idle = (pending == 8'h00) && (beats_left == 4'h0);
    assign next_pending = (i_hready && issue) ? (pending & ~i_hgrant) : pending;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pending <= 8'h00;
            armed <= 8'h00;
            beats_left <= 4'h0;
        end else begin
            armed <= pending;
            pending <= next_pending | i_start;
            if (i_hready && beats_left != 4'h0) begin
                beats_left <= beats_left - 4'h1;
            end else if (i_hready && issue) begin
                beats_left <= burst_len(i_burst);
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/ahb_arb_monitor.sv ***
// Notes on behaviour
// [RQ1] Main bus: order setting picks three high masters per fixed table.
// [RQ2] Video bus: order setting picks three high masters per its table.
// [RQ3] Video instance registers answer only the auxiliary core.
// [RQ4] Video instance has no clock or event counter registers.
// [RQ5] Control bits 23:20 and 19:16 select channel 1 and 0 masters.
// [RQ6] Control bits 14:12 and 10:8 select channel 1 and 0 events.
// [RQ7] Bits 2,1,0 enable channel 1, channel 0, clock counting.
// [RQ8] Event 0 counts active transfer cycles; event 1 counts NONSEQ.
// [RQ9] Event 2 sums cycles requests waited for grant.
// [RQ10] Event 3 bumps high field when one wait exceeds low threshold.
// [RQ11] Events 4,5,6 count SINGLE, fixed bursts, INCR bursts.
// [RQ12] Event 7 bumps high field when one transfer run exceeds threshold.
// [RQ13] Software ignores events 2,3,7 when all masters are selected.
// [RQ14] Master ids 0..7 select one master; 15 selects any.
// [RQ15] Clock counter is 48 bits: low register plus high bits 31:16.
// [RQ16] Event counters keep low 32 bits in own register; all writable.
// [RQ17] Event 1 high in bits 15:8, event 0 high in bits 7:0.
// [RQ18] High fields saturate at maximum until software rewrites them.
// [RQ19] Reserved control and order bits ignore writes, read zero.
// [RQ20] Within a group grants rotate round robin.
// [RQ21] High group requesters win over low group requesters.
// [RQ22] Enabled clock counter adds one per cycle with carry.
// [RQ23] Enabled channel counts selected events in its 40-bit counter.
`timescale 1ns/1ps
`default_nettype none

module ahb_arb_monitor #(
    parameter bit VIDEO_BUS = 1'b0
) (
    // Clock, reset, freeze
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Master requests and grants
    input wire logic [7:0] i_hbusreq,
    output logic [7:0] o_hgrant,
    output logic [3:0] o_hmaster,
    // Shared bus, observed and register slave
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic [2:0] i_hburst,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic [1:0] o_hresp
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic [1:0] group_order_sel;
    logic [3:0] chan_master_sel [2];
    logic [2:0] chan_event_sel [2];
    logic [1:0] chan_enable;
    logic cycle_count_enable;
    logic [31:0] cycle_count_low;
    logic [15:0] cycle_count_high;
    logic [31:0] chan_count_low [2];
    logic [7:0] chan_count_high [2];
    logic [31:0] span [2];
    logic [1:0] in_txn;
    logic [2:0] owner;
    logic [2:0] hi_last;
    logic [2:0] lo_last;
    logic wr_pend;
    logic [7:0] wr_addr;

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    function automatic logic [7:0] hi_group(input logic [1:0] sel);
        logic [31:0] tbl;
        tbl = VIDEO_BUS ? arb_mon_pkg::VIDEO_HI : arb_mon_pkg::MAIN_HI;
        return tbl[{sel, 3'h0} +: 8];
    endfunction

    wire [7:0] hi_mask = hi_group(group_order_sel); // RQ1 RQ2
    wire [7:0] hi_req = i_hbusreq & hi_mask;
    wire [7:0] lo_req = i_hbusreq & ~hi_mask;
    wire hi_found;
    wire lo_found;
    wire [2:0] hi_idx;
    wire [2:0] lo_idx;

    rr_pick u_hi_pick (
        .i_req(hi_req),
        .i_last(hi_last),
        .o_found(hi_found),
        .o_idx(hi_idx)
    );

    rr_pick u_lo_pick (
        .i_req(lo_req),
        .i_last(lo_last),
        .o_found(lo_found),
        .o_idx(lo_idx)
    );

    // Switch only at transfer boundaries so bursts stay whole
    wire boundary = i_htrans == arb_mon_pkg::TR_IDLE ||
        i_htrans == arb_mon_pkg::TR_NONSEQ;
    wire arb_take = i_ce && i_hready && boundary;
    wire [2:0] next_owner = hi_found ? hi_idx :
        (lo_found ? lo_idx : owner); // RQ21

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            owner <= 3'h0;
            hi_last <= 3'h7;
            lo_last <= 3'h7;
        end else if (arb_take) begin
            owner <= next_owner;
            if (hi_found) begin
                hi_last <= hi_idx; // RQ20
            end else if (lo_found) begin
                lo_last <= lo_idx; // RQ20
            end
        end
    end

    assign o_hgrant = 8'h01 << owner;
    assign o_hmaster = {1'b0, owner};

    // ----------------------------------------
    // Register slave
    // ----------------------------------------
    // Video instance trusts only the auxiliary core as requester
    wire access_ok = !VIDEO_BUS || owner == arb_mon_pkg::AUX_ID; // RQ3
    wire addr_take = i_ce && i_hsel && i_hready && i_htrans[1] &&
        access_ok;
    wire wr_now = i_ce && wr_pend;
    wire wr_prio = wr_now && wr_addr == arb_mon_pkg::OFF_PRIO;
    wire wr_ctrl = wr_now && wr_addr == arb_mon_pkg::OFF_CTRL;
    wire wr_bus_clock_count_low = wr_now && wr_addr == arb_mon_pkg::OFF_BUS_CLOCK_COUNT_LOW;
    wire wr_high = wr_now && wr_addr == arb_mon_pkg::OFF_HIGH;
    wire [1:0] wr_evl = {wr_now && wr_addr == arb_mon_pkg::OFF_EV1L,
        wr_now && wr_addr == arb_mon_pkg::OFF_EV0L};

    wire [31:0] ctrl_word = {8'h00, chan_master_sel[1],
        chan_master_sel[0], 1'b0, chan_event_sel[1], 1'b0,
        chan_event_sel[0], 5'h00, chan_enable,
        cycle_count_enable}; // RQ19
    wire [31:0] high_word = {cycle_count_high, chan_count_high[1],
        chan_count_high[0]};
    wire [31:0] rd_mux =
        i_haddr == arb_mon_pkg::OFF_PRIO ? {30'h0, group_order_sel} :
        i_haddr == arb_mon_pkg::OFF_CTRL ? ctrl_word :
        VIDEO_BUS ? 32'h0000_0000 : // RQ4
        i_haddr == arb_mon_pkg::OFF_BUS_CLOCK_COUNT_LOW ? cycle_count_low :
        i_haddr == arb_mon_pkg::OFF_EV0L ? chan_count_low[0] :
        i_haddr == arb_mon_pkg::OFF_EV1L ? chan_count_low[1] :
        i_haddr == arb_mon_pkg::OFF_HIGH ? high_word : 32'h0000_0000;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            o_hrdata <= arb_mon_pkg::RST_WORD;
        end else if (i_ce) begin
            if (i_hready) begin
                wr_pend <= addr_take && i_hwrite;
                wr_addr <= i_haddr;
            end
            if (addr_take && !i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 2'h0;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            group_order_sel <= 2'h0;
            chan_master_sel[0] <= 4'h0;
            chan_master_sel[1] <= 4'h0;
            chan_event_sel[0] <= 3'h0;
            chan_event_sel[1] <= 3'h0;
            chan_enable <= 2'h0;
            cycle_count_enable <= 1'b0;
        end else begin
            if (wr_prio) begin
                group_order_sel <= i_hwdata[arb_mon_pkg::PRIO_LSB +: 2];
            end
            if (wr_ctrl) begin
                chan_master_sel[0] <=
                    i_hwdata[arb_mon_pkg::MSEL0_LSB +: 4]; // RQ5
                chan_master_sel[1] <=
                    i_hwdata[arb_mon_pkg::MSEL1_LSB +: 4]; // RQ5
                chan_event_sel[0] <=
                    i_hwdata[arb_mon_pkg::EVSEL0_LSB +: 3]; // RQ6
                chan_event_sel[1] <=
                    i_hwdata[arb_mon_pkg::EVSEL1_LSB +: 3]; // RQ6
                chan_enable <= {i_hwdata[arb_mon_pkg::EN1_BIT],
                    i_hwdata[arb_mon_pkg::EN0_BIT]}; // RQ7
                cycle_count_enable <=
                    i_hwdata[arb_mon_pkg::CYCLE_COUNT_ENABLE_BIT]; // RQ7
            end
        end
    end

    // ----------------------------------------
    // Bus clock counter
    // ----------------------------------------
    wire [47:0] cc_full = {cycle_count_high, cycle_count_low};
    wire [47:0] next_cc = cc_full + 48'h1;
    // Holds at all ones rather than wrapping
    wire cc_inc = i_ce && cycle_count_enable && !(&cc_full) &&
        !VIDEO_BUS; // RQ22 RQ18

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cycle_count_low <= arb_mon_pkg::RST_WORD;
            cycle_count_high <= 16'h0000;
        end else begin
            if (wr_bus_clock_count_low) begin
                cycle_count_low <= i_hwdata; // RQ16
            end else if (cc_inc) begin
                cycle_count_low <= next_cc[31:0]; // RQ15
            end
            if (wr_high) begin
                cycle_count_high <=
                    i_hwdata[arb_mon_pkg::CYCLE_COUNT_HIGH_LSB +: 16]; // RQ15
            end else if (cc_inc) begin
                cycle_count_high <= next_cc[47:32]; // RQ15
            end
        end
    end

    // ----------------------------------------
    // Monitor channels
    // ----------------------------------------
    wire is_nonseq = i_htrans == arb_mon_pkg::TR_NONSEQ;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        localparam int HLSB = c ? arb_mon_pkg::EV1H_LSB :
            arb_mon_pkg::EV0H_LSB;
        wire [3:0] msel = chan_master_sel[c];
        wire [2:0] esel = chan_event_sel[c];
        wire mmatch = msel == arb_mon_pkg::MASTER_ALL ||
            msel == {1'b0, owner}; // RQ14
        wire act = i_hready && mmatch;
        wire e_active = act && i_htrans[1]; // RQ8
        wire e_nonseq = act && is_nonseq; // RQ8
        wire e_single = e_nonseq &&
            i_hburst == arb_mon_pkg::BURST_SINGLE; // RQ11
        wire e_incr = e_nonseq &&
            i_hburst == arb_mon_pkg::BURST_INCR; // RQ11
        wire e_fixed = e_nonseq && i_hburst[2:1] != 2'h0; // RQ11
        // Meaningless when every master is selected; software knows
        wire pend = i_hbusreq[msel[2:0]] && owner != msel[2:0]; // RQ13
        wire granted = arb_take && pend && next_owner == msel[2:0];
        wire [31:0] span_inc = span[c] + 32'h1;
        wire wait_trig = granted &&
            span_inc > chan_count_low[c]; // RQ10
        wire txn_end = i_hready && in_txn[c] &&
            (!mmatch || !i_htrans[1] || is_nonseq);
        wire act_trig = txn_end && span[c] > chan_count_low[c]; // RQ12
        wire inc_evt = chan_enable[c] && !VIDEO_BUS &&
            (esel == arb_mon_pkg::EV_ACTIVE ? e_active :
            esel == arb_mon_pkg::EV_NONSEQ ? e_nonseq :
            esel == arb_mon_pkg::EV_WAIT_SUM ? pend : // RQ9
            esel == arb_mon_pkg::EV_SINGLE ? e_single :
            esel == arb_mon_pkg::EV_FIXED ? e_fixed :
            esel == arb_mon_pkg::EV_INCR ? e_incr : 1'b0); // RQ23
        wire trig_evt = chan_enable[c] && !VIDEO_BUS &&
            (esel == arb_mon_pkg::EV_WAIT_TRIG ? wait_trig :
            esel == arb_mon_pkg::EV_ACT_TRIG ? act_trig : 1'b0);
        wire [39:0] cnt = {chan_count_high[c], chan_count_low[c]};
        wire [39:0] next_cnt = cnt + 40'h1;
        wire cnt_inc = i_ce && inc_evt && !(&cnt); // RQ18
        wire hi_inc = i_ce && trig_evt &&
            chan_count_high[c] != 8'hFF; // RQ18
        wire span_wait = esel == arb_mon_pkg::EV_WAIT_TRIG;

        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                chan_count_low[c] <= arb_mon_pkg::RST_WORD;
                chan_count_high[c] <= 8'h00;
            end else begin
                if (wr_evl[c]) begin
                    chan_count_low[c] <= i_hwdata; // RQ16
                end else if (cnt_inc) begin
                    chan_count_low[c] <= next_cnt[31:0]; // RQ23
                end
                if (wr_high) begin
                    chan_count_high[c] <= i_hwdata[HLSB +: 8]; // RQ17
                end else if (cnt_inc) begin
                    chan_count_high[c] <= next_cnt[39:32]; // RQ23
                end else if (hi_inc) begin
                    chan_count_high[c] <= chan_count_high[c] + 8'h01;
                end
            end
        end

        // Span counts wait cycles or active cycles of one transfer run
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                span[c] <= 32'h0000_0000;
                in_txn[c] <= 1'b0;
            end else if (i_ce) begin
                if (span_wait) begin
                    in_txn[c] <= 1'b0;
                    if (granted || !pend) begin
                        span[c] <= 32'h0000_0000;
                    end else if (arb_take || i_hready) begin
                        span[c] <= span_inc;
                    end
                end else if (e_nonseq) begin
                    span[c] <= 32'h0000_0001;
                    in_txn[c] <= 1'b1;
                end else if (txn_end) begin
                    span[c] <= 32'h0000_0000;
                    in_txn[c] <= 1'b0;
                end else if (e_active && in_txn[c]) begin
                    span[c] <= span_inc;
                end
            end
        end

        chk_ev_nonseq: assert property (@(posedge i_clk_sys)
            disable iff (i_rst) // RQ8
            i_ce && chan_enable[c] && esel == arb_mon_pkg::EV_NONSEQ &&
            e_nonseq && !wr_now && !(&cnt) && !VIDEO_BUS
            |=> chan_count_low[c] == $past(chan_count_low[c]) + 32'h1)
            else $error("nonseq event not counted");

        chk_high_sat: assert property (@(posedge i_clk_sys)
            disable iff (i_rst) // RQ18
            chan_count_high[c] == 8'hFF && !wr_high
            |=> chan_count_high[c] == 8'hFF)
            else $error("event high field wrapped");
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_hi_preempt: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ21
        arb_take && |hi_req |=> |($past(hi_mask) & o_hgrant))
        else $error("low group won over high request");

    chk_rr_rotate: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ20
        arb_take && $countones(hi_req) > 1 && hi_req[owner]
        |=> owner != $past(owner))
        else $error("round robin did not rotate");

    chk_prio_rsvd: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ19
        addr_take && !i_hwrite && i_haddr == arb_mon_pkg::OFF_PRIO
        |=> o_hrdata[31:2] == 30'h0)
        else $error("reserved order bits read nonzero");

    chk_ctrl_fields: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ5
        wr_ctrl |=> chan_master_sel[1] == $past(i_hwdata[23:20]) &&
        chan_master_sel[0] == $past(i_hwdata[19:16]))
        else $error("master select not written");

    chk_clk_count: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ22
        cc_inc && !wr_bus_clock_count_low && !wr_high
        |=> cc_full == $past(cc_full) + 48'h1)
        else $error("clock counter missed a cycle");

    chk_clk_hold: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ7
        !cycle_count_enable && !wr_bus_clock_count_low && !wr_high |=> $stable(cc_full))
        else $error("clock counter moved while disabled");

    chk_video_gate: assert property (@(posedge i_clk_sys)
        disable iff (i_rst) // RQ3
        i_ce && i_hready && !access_ok |=> !wr_pend)
        else $error("foreign master reached video registers");

endmodule

`default_nettype wire

// *** verilog/arb_mon_pkg.sv ***
package arb_mon_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PRIO = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_BUS_CLOCK_COUNT_LOW = 8'h08;
    localparam logic [7:0] OFF_EV0L = 8'h0C;
    localparam logic [7:0] OFF_EV1L = 8'h10;
    localparam logic [7:0] OFF_HIGH = 8'h14;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int PRIO_LSB = 0;
    localparam int CYCLE_COUNT_ENABLE_BIT = 0;
    localparam int EN0_BIT = 1;
    localparam int EN1_BIT = 2;
    localparam int EVSEL0_LSB = 8;
    localparam int EVSEL1_LSB = 12;
    localparam int MSEL0_LSB = 16;
    localparam int MSEL1_LSB = 20;
    localparam int CYCLE_COUNT_HIGH_LSB = 16;
    localparam int EV1H_LSB = 8;
    localparam int EV0H_LSB = 0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ----------------------------------------
    // Master identifiers and group tables
    // ----------------------------------------
    localparam logic [3:0] MASTER_ALL = 4'hF;
    // Auxiliary core position on the video bus
    localparam logic [2:0] AUX_ID = 3'h0;
    // High groups, one byte per order setting, setting 0 lowest
    localparam logic [31:0] MAIN_HI = 32'h1A13_1516;
    localparam logic [31:0] VIDEO_HI = 32'h0783_9213;

    // ----------------------------------------
    // Bus encodings
    // ----------------------------------------
    localparam logic [1:0] TR_IDLE = 2'h0;
    localparam logic [1:0] TR_NONSEQ = 2'h2;
    localparam logic [1:0] TR_SEQ = 2'h3;
    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR = 3'h1;

    typedef enum logic [2:0] {
        EV_ACTIVE,
        EV_NONSEQ,
        EV_WAIT_SUM,
        EV_WAIT_TRIG,
        EV_SINGLE,
        EV_FIXED,
        EV_INCR,
        EV_ACT_TRIG
    } event_t;

endpackage

// *** verilog/rr_pick.sv ***
`timescale 1ns/1ps
`default_nettype none

module rr_pick (
    // Requests and rotation point
    input wire logic [7:0] i_req,
    input wire logic [2:0] i_last,
    // Choice
    output logic o_found,
    output logic [2:0] o_idx
);

    logic [2:0] probe;

    // --------------------------------------
    // Search starts just past the last winner
    // --------------------------------------
    always_comb begin
        probe = i_last;
        o_found = 1'b0;
        o_idx = i_last;
        for (int k = 1; k <= 8; k++) begin
            probe = i_last + 3'(k);
            if (!o_found && i_req[probe]) begin
                o_found = 1'b1;
                o_idx = probe;
            end
        end
    end

endmodule

`default_nettype wire
